// >>> lcdsd_pkg.sv
package lcdsd_pkg;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] OPC_MODE = 4'hC;
    localparam logic [4:0] OPC_DEVSEL = 5'h1C;
    localparam logic [5:0] OPC_BANK = 6'h3E;
    localparam logic [4:0] OPC_BLINK = 5'h1E;
    localparam logic [1:0] MODE_STATIC = 2'h1;
    localparam logic [1:0] MODE_MUX2 = 2'h2;
    localparam logic [1:0] MODE_MUX3 = 2'h3;
    localparam logic [1:0] MODE_MUX4 = 2'h0;
    localparam int RAM_COLS = 60;
    localparam logic [6:0] PTR_LAST = 7'h3B;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h1C;
    localparam logic [11:0] BLINK_DIV1 = 12'h300;
    localparam logic [11:0] BLINK_DIV2 = 12'h600;
    localparam logic [11:0] BLINK_DIV3 = 12'hC00;
    localparam logic RST_DISPLAY_EN = 1'b0;
    localparam logic RST_BIAS = 1'b0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [6:0] RST_PTR = 7'h00;
    localparam logic [2:0] RST_SUBADDR = 3'h0;
    localparam logic RST_BANK = 1'b0;
    localparam logic RST_ALT_BLINK = 1'b0;
    localparam logic [1:0] RST_BLINK_RATE = 2'h0;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam int CLK_MHZ = 100;
    localparam int SCL_KHZ = 100;
    localparam int QTR_CYC = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
endpackage : lcdsd_pkg

// >>> lcdsd_if.sv
interface lcdsd_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    // Open-drain wires: any enabled driver pulls low, otherwise the pull-up wins.
    assign scl = m_scl_oe ? m_scl_o : 1'b1;
    assign sda = (m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o) ? 1'b0 : 1'b1;
    modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
    modport device (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : lcdsd_if

// >>> lcdsd_dev.sv
module lcdsd_dev
    import lcdsd_pkg::*;
(
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset.
    lcdsd_if.device bus, // Serial bus end.
    input wire logic i_addr_pin_level, // Slave address bit 1.
    input wire logic [2:0] i_hw_subaddr, // Hardware subaddress.
    input wire logic i_disp_tick, // Display clock pulse.
    input wire logic [5:0] i_rd_col, // RAM column to read.
    output logic [3:0] o_rd_bits, // RAM column contents.
    output logic o_display_en, // Display enable.
    output logic o_bias_half, // Half bias chosen.
    output logic [1:0] o_drive_mode, // Drive mode field.
    output logic o_blank, // Outputs at LCD supply.
    output logic [1:0] o_disp_row_base, // First row shown.
    output logic o_in_bank, // Input bank bit.
    output logic o_out_bank, // Output bank bit.
    output logic o_alt_bank_blink_bit, // Blink style bit.
    output logic [1:0] o_blink_rate_field, // Blink rate.
    output logic [6:0] o_data_ptr, // Data pointer.
    output logic [2:0] o_subaddr // Subaddress counter.
);
    typedef enum {PH_IDLE, PH_ADDR, PH_CTRL, PH_BYTE, PH_SKIP} lcdsd_ph_t;
    lcdsd_ph_t ph_reg;
    logic scl_q_reg, sda_q_reg, more_reg, target_reg, ack_pend_reg, sda_oe_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic en_reg, bias_reg, in_bank_reg, out_bank_reg, alt_reg;
    logic [1:0] mode_reg, rate_reg;
    logic [6:0] ptr_reg;
    logic [2:0] sub_reg;
    logic wr_busy_reg, wr_match_reg;
    logic [7:0] wr_bits_reg;
    logic [3:0] wr_left_reg;
    logic [1:0] row_reg;
    logic [3:0] ram_reg [RAM_COLS];
    logic [11:0] blink_cnt_reg;
    logic blink_ph_reg, blank_reg;
    logic [1:0] disp_base_reg;
    logic [3:0] rd_reg;
    ////////////////////////////////////////////////////////////////////////////
    wire start_c = scl_q_reg & bus.scl & sda_q_reg & ~bus.sda;
    wire stop_c = scl_q_reg & bus.scl & ~sda_q_reg & bus.sda;
    wire scl_rise = ~scl_q_reg & bus.scl;
    wire scl_fall = scl_q_reg & ~bus.scl;
    wire byte_done = scl_rise && bit_cnt_reg == 4'h7 && ph_reg != PH_IDLE;
    wire [7:0] byte_w = {shift_reg[6:0], bus.sda};
    wire in_byte = byte_done && ph_reg == PH_BYTE;
    wire cmd_stb = in_byte & ~target_reg;
    wire data_stb = in_byte & target_reg;
    wire sub_hit = sub_reg == i_hw_subaddr;
    wire bank_ok = mode_reg == MODE_STATIC || mode_reg == MODE_MUX2;
    wire [1:0] rows_m1 = mode_reg - 2'h1;
    wire [1:0] in_base = (bank_ok && in_bank_reg) ? 2'h2 : 2'h0;
    wire adv = wr_busy_reg && (row_reg == rows_m1 || wr_left_reg == 4'h1);
    wire alt_eff = alt_reg & bank_ok;
    wire blink_on = rate_reg != 2'h0;
    wire [11:0] blink_half = (rate_reg == 2'h1) ? (BLINK_DIV1 >> 1) :
                             (rate_reg == 2'h2) ? (BLINK_DIV2 >> 1) : (BLINK_DIV3 >> 1);
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = sda_oe_reg;
    assign o_rd_bits = rd_reg;
    assign o_display_en = en_reg;
    assign o_bias_half = bias_reg;
    assign o_drive_mode = mode_reg;
    assign o_blank = blank_reg;
    assign o_disp_row_base = disp_base_reg;
    assign o_in_bank = in_bank_reg;
    assign o_out_bank = out_bank_reg;
    assign o_alt_bank_blink_bit = alt_reg;
    assign o_blink_rate_field = rate_reg;
    assign o_data_ptr = ptr_reg;
    assign o_subaddr = sub_reg;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        scl_q_reg <= i_rst ? 1'b1 : bus.scl;
        sda_q_reg <= i_rst ? 1'b1 : bus.sda;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ph_reg <= PH_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            more_reg <= 1'b0;
            target_reg <= 1'b0;
        end else if (stop_c) begin
            ph_reg <= PH_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (start_c) begin
            ph_reg <= PH_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise && ph_reg != PH_IDLE) begin
            shift_reg <= byte_w;
            bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
            if (byte_done) begin
                unique case (ph_reg)
                    PH_ADDR: ph_reg <= (byte_w == {SLAVE_ADDR_HI, i_addr_pin_level, 1'b0})
                                       ? PH_CTRL : PH_SKIP;
                    PH_CTRL: begin
                        more_reg <= byte_w[7];
                        target_reg <= byte_w[6];
                        ph_reg <= PH_BYTE;
                    end
                    PH_BYTE: ph_reg <= more_reg ? PH_CTRL : PH_BYTE;
                    PH_IDLE, PH_SKIP: ph_reg <= ph_reg;
                endcase
            end
        end
    end

    // Acknowledge is driven from the fall after bit 8 until the next fall.
    always_ff @(posedge i_clk) begin
        if (i_rst || start_c || stop_c) begin
            ack_pend_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (byte_done) begin
            ack_pend_reg <= (ph_reg == PH_ADDR)
                            ? (byte_w == {SLAVE_ADDR_HI, i_addr_pin_level, 1'b0})
                            : (ph_reg == PH_CTRL || cmd_stb || (data_stb && sub_hit));
        end else if (scl_fall) begin
            sda_oe_reg <= ack_pend_reg;
            ack_pend_reg <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // settings held here
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_reg <= RST_DISPLAY_EN;
            bias_reg <= RST_BIAS;
            mode_reg <= RST_MODE;
            in_bank_reg <= RST_BANK;
            out_bank_reg <= RST_BANK;
            alt_reg <= RST_ALT_BLINK;
            rate_reg <= RST_BLINK_RATE;
        end else if (cmd_stb) begin
            if (byte_w[7:4] == OPC_MODE) begin
                en_reg <= byte_w[3];
                bias_reg <= byte_w[2];
                mode_reg <= byte_w[1:0];
            end
            if (byte_w[7:2] == OPC_BANK) begin
                in_bank_reg <= byte_w[1];
                out_bank_reg <= byte_w[0];
            end
            if (byte_w[7:3] == OPC_BLINK) begin
                alt_reg <= byte_w[2];
                rate_reg <= byte_w[1:0];
            end
        end
    end

    // Pointer and counter are shared by the load commands and the writer.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ptr_reg <= RST_PTR;
            sub_reg <= RST_SUBADDR;
        end else if (cmd_stb && !byte_w[7]) begin
            ptr_reg <= byte_w[6:0];
        end else if (cmd_stb && byte_w[7:3] == OPC_DEVSEL) begin
            sub_reg <= byte_w[2:0];
        end else if (adv) begin
            ptr_reg <= (ptr_reg >= PTR_LAST) ? 7'h00 : ptr_reg + 7'h01;
            sub_reg <= (ptr_reg >= PTR_LAST) ? sub_reg + 3'h1 : sub_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // filling order writer
    // One bit per clock, MSB first; a partly filled column still advances.
    // Other devices advance too, so cascaded parts stay in step.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_busy_reg <= 1'b0;
            wr_match_reg <= 1'b0;
            wr_bits_reg <= 8'h00;
            wr_left_reg <= 4'h0;
            row_reg <= 2'h0;
        end else if (data_stb) begin
            wr_busy_reg <= 1'b1;
            wr_match_reg <= sub_hit;
            wr_bits_reg <= byte_w;
            wr_left_reg <= 4'h8;
            row_reg <= 2'h0;
        end else if (wr_busy_reg) begin
            wr_bits_reg <= {wr_bits_reg[6:0], 1'b0};
            wr_left_reg <= wr_left_reg - 4'h1;
            wr_busy_reg <= wr_left_reg != 4'h1;
            row_reg <= (row_reg == rows_m1) ? 2'h0 : row_reg + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (wr_busy_reg && wr_match_reg && ptr_reg <= PTR_LAST) begin
            ram_reg[ptr_reg[5:0]][in_base + row_reg] <= wr_bits_reg[7];
        end
        rd_reg <= (i_rd_col <= PTR_LAST[5:0]) ? ram_reg[i_rd_col] : 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // blink divider
    always_ff @(posedge i_clk) begin
        if (i_rst || !blink_on) begin
            blink_cnt_reg <= 12'h000;
            blink_ph_reg <= 1'b0;
        end else if (i_disp_tick) begin
            blink_cnt_reg <= (blink_cnt_reg >= blink_half - 12'h001) ? 12'h000
                             : blink_cnt_reg + 12'h001;
            blink_ph_reg <= blink_ph_reg ^ (blink_cnt_reg >= blink_half - 12'h001);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blank_reg <= 1'b1;
            disp_base_reg <= 2'h0;
        end else begin
            blank_reg <= !en_reg || (blink_on && !alt_eff && blink_ph_reg);
            disp_base_reg <= (bank_ok && (out_bank_reg ^ (alt_eff && blink_on
                              && blink_ph_reg))) ? 2'h2 : 2'h0;
        end
    end
    // Unknown opcodes match no branch above and change nothing.
endmodule : lcdsd_dev

// >>> lcdsd_host.sv
module lcdsd_host
    import lcdsd_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int QTR = QTR_CYC
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset.
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr, // Write address.
    input wire logic i_s_axi_awvalid, // Write address valid.
    output logic o_s_axi_awready, // Write address ready.
    input wire logic [31:0] i_s_axi_wdata, // Write data.
    input wire logic [3:0] i_s_axi_wstrb, // Write strobes.
    input wire logic i_s_axi_wvalid, // Write data valid.
    output logic o_s_axi_wready, // Write data ready.
    output logic [1:0] o_s_axi_bresp, // Write response.
    output logic o_s_axi_bvalid, // Write response valid.
    input wire logic i_s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] i_s_axi_araddr, // Read address.
    input wire logic i_s_axi_arvalid, // Read address valid.
    output logic o_s_axi_arready, // Read address ready.
    output logic [31:0] o_s_axi_rdata, // Read data.
    output logic [1:0] o_s_axi_rresp, // Read response.
    output logic o_s_axi_rvalid, // Read valid.
    input wire logic i_s_axi_rready, // Read ready.
    lcdsd_if.master bus // Serial bus end.
);
    typedef enum {H_IDLE, H_WAIT, H_RS1, H_RS2, H_ST, H_BL, H_BR, H_BH,
                  H_AL, H_AR, H_AH, H_P1, H_P2, H_P3} lcdsd_hst_t;
    lcdsd_hst_t st_reg;
    logic awr_reg, wr_reg, bv_reg, arr_reg, rv_reg, aw_have_reg, w_have_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [9:0] wdata_reg, cmd_reg;
    logic [15:0] q_reg;
    logic [2:0] idx_reg;
    logic scl_oe_reg, sda_oe_reg, owned_reg, nack_reg;
    ////////////////////////////////////////////////////////////////////////////
    wire fire = aw_have_reg && w_have_reg && !bv_reg;
    wire hit_cmd = awaddr_reg == REG_CMD[ADDR_W-1:0];
    wire go = fire && hit_cmd && st_reg == H_IDLE;
    wire tick = q_reg == 16'(QTR - 1);
    wire ar_hit = i_s_axi_araddr == REG_CMD[ADDR_W-1:0]
                  || i_s_axi_araddr == REG_STATUS[ADDR_W-1:0];
    assign o_s_axi_awready = awr_reg;
    assign o_s_axi_wready = wr_reg;
    assign o_s_axi_bresp = bresp_reg;
    assign o_s_axi_bvalid = bv_reg;
    assign o_s_axi_arready = arr_reg;
    assign o_s_axi_rdata = rdata_reg;
    assign o_s_axi_rresp = rresp_reg;
    assign o_s_axi_rvalid = rv_reg;
    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = scl_oe_reg;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = sda_oe_reg;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            awr_reg <= 1'b1;
            wr_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bv_reg <= 1'b0;
            bresp_reg <= AXI_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= 10'h000;
        end else begin
            if (awr_reg && i_s_axi_awvalid) begin
                awr_reg <= 1'b0;
                aw_have_reg <= 1'b1;
                awaddr_reg <= i_s_axi_awaddr;
            end
            if (wr_reg && i_s_axi_wvalid) begin
                wr_reg <= 1'b0;
                w_have_reg <= 1'b1;
                // A command needs its data byte lane; otherwise it is cleared to 10'h000 and still issued.
                wdata_reg <= i_s_axi_wstrb[0] ? i_s_axi_wdata[9:0] : 10'h000;
            end
            if (fire) begin
                bv_reg <= 1'b1;
                bresp_reg <= (hit_cmd || awaddr_reg == REG_STATUS[ADDR_W-1:0])
                             ? AXI_OKAY : AXI_SLVERR;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end
            if (bv_reg && i_s_axi_bready) begin
                bv_reg <= 1'b0;
                awr_reg <= 1'b1;
                wr_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arr_reg <= 1'b1;
            rv_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= AXI_OKAY;
        end else if (arr_reg && i_s_axi_arvalid) begin
            arr_reg <= 1'b0;
            rv_reg <= 1'b1;
            rresp_reg <= ar_hit ? AXI_OKAY : AXI_SLVERR;
            rdata_reg <= (i_s_axi_araddr == REG_CMD[ADDR_W-1:0]) ? {22'h0, cmd_reg}
                         : ar_hit ? {28'h0, bus.scl & bus.sda, owned_reg, nack_reg,
                                     st_reg != H_IDLE} : 32'h00000000;
        end else if (rv_reg && i_s_axi_rready) begin
            rv_reg <= 1'b0;
            arr_reg <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Quarter-period timebase; each engine step lasts one tick, and each SCL bit period takes three steps.
    always_ff @(posedge i_clk) begin
        q_reg <= (i_rst || st_reg == H_IDLE || tick) ? 16'h0000 : q_reg + 16'h0001;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= H_IDLE;
            cmd_reg <= 10'h000;
            idx_reg <= 3'h7;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            owned_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else if (st_reg == H_IDLE) begin
            if (go && wdata_reg[CMD_START_BIT]) begin
                cmd_reg <= wdata_reg;
                st_reg <= owned_reg ? H_RS1 : H_WAIT;
            end else if (go) begin
                cmd_reg <= wdata_reg;
                st_reg <= H_BL;
            end
        end else if (tick) begin
            unique case (st_reg)
                H_WAIT: if (bus.scl && bus.sda) begin
                    sda_oe_reg <= 1'b1;
                    owned_reg <= 1'b1;
                    st_reg <= H_ST;
                end
                H_RS1: begin
                    sda_oe_reg <= 1'b0;
                    st_reg <= H_RS2;
                end
                H_RS2: begin
                    scl_oe_reg <= 1'b0;
                    st_reg <= H_WAIT;
                end
                H_ST: begin
                    scl_oe_reg <= 1'b1;
                    idx_reg <= 3'h7;
                    st_reg <= H_BL;
                end
                // data changes only while SCL low
                H_BL: begin
                    sda_oe_reg <= ~cmd_reg[idx_reg];
                    st_reg <= H_BR;
                end
                H_BR: begin
                    scl_oe_reg <= 1'b0;
                    st_reg <= H_BH;
                end
                H_BH: begin
                    scl_oe_reg <= 1'b1;
                    idx_reg <= idx_reg - 3'h1;
                    st_reg <= (idx_reg == 3'h0) ? H_AL : H_BL;
                end
                H_AL: begin
                    sda_oe_reg <= 1'b0;
                    st_reg <= H_AR;
                end
                H_AR: begin
                    scl_oe_reg <= 1'b0;
                    st_reg <= H_AH;
                end
                H_AH: begin
                    nack_reg <= bus.sda;
                    scl_oe_reg <= 1'b1;
                    st_reg <= cmd_reg[CMD_STOP_BIT] ? H_P1 : H_IDLE;
                end
                H_P1: begin
                    sda_oe_reg <= 1'b1;
                    st_reg <= H_P2;
                end
                H_P2: begin
                    scl_oe_reg <= 1'b0;
                    st_reg <= H_P3;
                end
                H_P3: begin
                    sda_oe_reg <= 1'b0;
                    owned_reg <= 1'b0;
                    st_reg <= H_IDLE;
                end
                default: st_reg <= H_IDLE;
            endcase
        end
    end
endmodule : lcdsd_host

// >>> lcdsd_properties.sv
module lcdsd_properties (
    input wire logic i_clk, // Clock.
    input wire logic i_rst, // Reset.
    input wire logic scl, // Clock line.
    input wire logic sda, // Data line.
    input wire logic m_scl_oe, // Host pulls clock.
    input wire logic m_sda_oe, // Host pulls data.
    input wire logic s_sda_oe // Device pulls data.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence start_s;
        $fell(sda) && scl && $past(scl);
    endsequence
    sequence stop_s;
        $rose(sda) && scl && $past(scl);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    start_rel_a: assert property (start_s |=> !s_sda_oe [*4])
        else $error("device pulls data after start");
    start_clk_a: assert property (start_s |-> ##[1:20] !scl)
        else $error("no clock after start");
    stop_idle_a: assert property (stop_s |=> (!s_sda_oe && !m_scl_oe) [*3])
        else $error("bus not idle after stop");
    ack_hold_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("ack moved while clock high");
    ack_phase_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("ack changed with clock high");
    clk_high_a: assert property ($rose(scl) |-> scl [*3])
        else $error("clock high too short");
    data_hold_a: assert property ($rose(scl) |=> $stable(sda) [*2])
        else $error("data moved while clock high");
    reset_idle_a: assert property ($fell(i_rst) |-> !s_sda_oe && !m_scl_oe && !m_sda_oe)
        else $error("bus held after reset");
endmodule : lcdsd_properties

// >>> test_lcd_segment_command_decoder.sv
module test_lcd_segment_command_decoder;
    import lcdsd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'h0, i_rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rd, st;
    logic awr, wr, bv, arr, rv, pin = 1'h0, tick = 1'h0, en, bias, blank, ib, ob, ab;
    logic [1:0] bres, rres, mode, base, bf, r;
    logic [5:0] col = 6'h0;
    logic [3:0] bits;
    logic [6:0] ptr, e_ptr = 7'h0;
    logic [2:0] sub, e_sub = 3'h0;
    logic e_en = 1'h0, e_bias = 1'h0, e_ib = 1'h0, e_ob = 1'h0, e_ab = 1'h0;
    logic [1:0] e_mode = 2'h0, e_bf = 2'h0;
    logic [7:0] corner [6] = '{8'hE7, 8'h3B, 8'hFF, 8'hD5, 8'hFA, 8'hEB};
    logic [7:0] setup [5] = '{8'hE0, 8'hF8, 8'hF0, 8'hC9, 8'h00};
    int fail_count = 0, checked = 0, cycles = 0, half_n = 0;
    logic tick_on = 1'h0;
    logic [7:0] cb = 8'h00;
    integer seed = 32'hBA0C;
    always #5 i_clk = ~i_clk;
    lcdsd_if bus_if();
    lcdsd_host #(.QTR(4)) i_lcdsd_host(.i_clk(i_clk), .i_rst(i_rst), .i_s_axi_awaddr(awa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(bres), .o_s_axi_bvalid(bv),
        .i_s_axi_bready(br), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(rres), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
        .bus(bus_if));
    lcdsd_dev i_lcdsd_dev(.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if), .i_addr_pin_level(pin),
        .i_hw_subaddr(3'h0), .i_disp_tick(tick), .i_rd_col(col), .o_rd_bits(bits),
        .o_display_en(en), .o_bias_half(bias), .o_drive_mode(mode), .o_blank(blank),
        .o_disp_row_base(base), .o_in_bank(ib), .o_out_bank(ob), .o_alt_bank_blink_bit(ab),
        .o_blink_rate_field(bf), .o_data_ptr(ptr), .o_subaddr(sub));
    lcdsd_properties i_lcdsd_properties(.i_clk(i_clk), .i_rst(i_rst), .scl(bus_if.scl),
        .sda(bus_if.sda), .m_scl_oe(bus_if.m_scl_oe), .m_sda_oe(bus_if.m_sda_oe),
        .s_sda_oe(bus_if.s_sda_oe));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task end_sim;
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
        do begin
            @(posedge i_clk);
            if (awr) awv <= 1'h0;
            if (wr) wv <= 1'h0;
        end while (!bv);
        r = bres;
        br <= 1'h0;
    endtask : axw
    task axr(input logic [7:0] a);
        @(posedge i_clk);
        ara <= a; arv <= 1'h1; rr <= 1'h1;
        do begin
            @(posedge i_clk);
            if (arr) arv <= 1'h0;
        end while (!rv);
        st = rd; r = rres;
        rr <= 1'h0;
    endtask : axr
    // Each byte is waited out, since the host ignores commands while busy.
    task send(input logic [9:0] c);
        axw(REG_CMD, {22'h0, c});
        do axr(REG_STATUS); while (st[0] !== 1'h0);
    endtask : send
    task xfer(input logic [7:0] ctl, input logic [7:0] b);
        send({2'h1, SLAVE_ADDR_HI, 2'h0});
        send({2'h0, ctl});
        send({2'h2, b});
    endtask : xfer
    function void model(input logic [7:0] b);
        if (b[7] == 1'h0) e_ptr = b[6:0];
        else if (b[7:4] == OPC_MODE) {e_en, e_bias, e_mode} = b[3:0];
        else if (b[7:3] == OPC_DEVSEL) e_sub = b[2:0];
        else if (b[7:2] == OPC_BANK) {e_ib, e_ob} = b[1:0];
        else if (b[7:3] == OPC_BLINK) {e_ab, e_bf} = b[2:0];
    endfunction : model
    function logic [7:0] pick();
        logic [31:0] v;
        v = $random(seed);
        case (v[10:8])
            3'h0: return {4'hC, v[3:0]};
            3'h1: return {1'h0, v[6:0] % 7'h3C};
            3'h2: return {5'h1C, v[2:0]};
            3'h3: return {6'h3E, v[1:0]};
            3'h4: return {5'h1E, v[2:0]};
            default: return {4'hD, v[3:0]};
        endcase
    endfunction : pick
    task check_all;
        chk("settings", {en, bias, mode, ib, ob, ab, bf, ptr, sub},
            {e_en, e_bias, e_mode, e_ib, e_ob, e_ab, e_bf, e_ptr, e_sub});
        chk("row base", base, (e_ob && (e_mode[0] ^ e_mode[1])) ? 2'h2 : 2'h0);
    endtask : check_all
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        // Display ticks stay off until the blink check, so the shown bank is predictable.
        tick <= tick_on;
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        axw(8'h10, 32'h1);
        chk("write resp", r, AXI_SLVERR);
        axr(8'h10);
        chk("read data", st, 32'h0);
        chk("read resp", r, AXI_SLVERR);
        check_all();
        chk("blank reset", blank, 1'h1);
        for (int i = 0; i < 40; i++) begin
            cb = i < 6 ? corner[i] : pick();
            xfer(8'h00, cb);
            model(cb);
            check_all();
            chk("ack", st[1], 1'h0);
        end
        // Another address pin makes the whole transfer be ignored.
        pin <= 1'h1;
        xfer(8'h00, 8'hCF);
        chk("nack", st[1], 1'h1);
        check_all();
        pin <= 1'h0;
        foreach (setup[i]) begin
            xfer(8'h00, setup[i]);
            model(setup[i]);
        end
        xfer(8'h40, 8'hA5);
        e_ptr = 7'h08;
        check_all();
        chk("blank", blank, 1'h0);
        for (int c = 0; c < 8; c++) begin
            col <= c[5:0];
            repeat (2) @(posedge i_clk);
            chk("ram bit", bits[0], {3'h0, 8'hA5 >> (7 - c)} & 4'h1);
        end
        // Normal blink at rate 1 with a tick every cycle blanks for half a blink period.
        xfer(8'h00, 8'hF1);
        model(8'hF1);
        tick_on <= 1'h1;
        while (blank !== 1'h1) @(posedge i_clk);
        while (blank === 1'h1) begin
            half_n++;
            @(posedge i_clk);
        end
        chk("blink half", half_n, BLINK_DIV1 >> 1);
        end_sim();
    end
endmodule : test_lcd_segment_command_decoder
